// ==== logic/avrp_defines.svh ====
// Constant definitions for the angle and velocity read-out port.
`ifndef AVRP_DEFINES_SVH
`define AVRP_DEFINES_SVH
`define AVRP_DATA_W        12
`define AVRP_WORD_W        16
`define AVRP_SYS_CLK_KHZ   10000
`define AVRP_SCLK_MAX_KHZ  25000
`define AVRP_DATA_LSB      4
`define AVRP_SEL_BIT       3
`define AVRP_DEGRADE_BIT   2
`define AVRP_LOST_BIT      1
`define AVRP_CHECK_BIT     0
`define AVRP_SO_PIN        11
`define AVRP_SCLK_PIN      10
`define AVRP_RST_DATA      12'h000
`define AVRP_RST_WORD      16'h0000
`endif

// ==== logic/avrp_pkg.sv ====
// Types shared by the read-out port modules.
`include "avrp_defines.svh"
package avrp_pkg;
	typedef logic [`AVRP_DATA_W-1:0] avrp_data_t;
	typedef logic [`AVRP_WORD_W-1:0] avrp_word_t;
	typedef enum logic {AVRP_IDLE, AVRP_FRAME} avrp_frame_e;
endpackage : avrp_pkg

// ==== logic/avrp_sync.sv ====
// Two-flop synchroniser with edge detection on the synchronised level.
module avrp_sync
	import avrp_pkg::*;
(
	input  wire logic SYS_CLK,
	input  wire logic RST,
	input  wire logic din,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed
	{
		logic meta_ff;
		logic sync_ff;
		logic last_ff;
	} avrp_sync_s;

	avrp_sync_s st_ff;
	avrp_sync_s nxt_st;

	always_comb
	begin
		nxt_st         = st_ff;
		nxt_st.meta_ff = din;
		nxt_st.sync_ff = st_ff.meta_ff;
		nxt_st.last_ff = st_ff.sync_ff;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			st_ff <= '{meta_ff: 1'b1, sync_ff: 1'b1, last_ff: 1'b1};
		else
			st_ff <= nxt_st;
	end

	assign level = st_ff.sync_ff;
	assign rise  = st_ff.sync_ff & ~st_ff.last_ff;
	assign fall  = ~st_ff.sync_ff & st_ff.last_ff;
endmodule : avrp_sync

// ==== logic/avrp_word.sv ====
// Builds the 16-bit serial word with its odd check bit.
module avrp_word
	import avrp_pkg::*;
(
	input  wire avrp_data_t data,
	input  wire logic       select,
	input  wire logic       degrade,
	input  wire logic       lost,
	output avrp_word_t      word
);
	logic [`AVRP_WORD_W-2:0] body;

	always_comb
	begin
		body = {data, select, degrade, lost};
		word = {body, ~(^body)};
	end
endmodule : avrp_word

// ==== logic/avrp_port.sv ====
// Read-out port: holding registers, parallel bus and serial shift port.
//
// Operation
// - Parallel pins float; drive only while chip select and read strobe are low.
// - Read strobe falling edge copies the selected holding register to output.
// - Read strobe rising returns parallel pins to high impedance.
// - Latch strobe falling edge copies both integrators into holding registers.
// - Integrators keep updating during reads; only holding registers freeze.
// - Serial mode: pin 11 is data out, pin 10 clock in, 0-9 float.
// - Serial clock up to 25 MHz; host never exceeds it.
// - Select high picks position, low velocity; transfer only with chip select low.
// - Serial output comes from a 16-bit shift register, one word per frame.
// - Word sent MSB first; bits 15 to 4 carry the 12-bit value.
// - Position is unsigned binary, zero to full turn minus one LSB.
// - Velocity is twos complement; MSB gives rotation direction.
// - Bit 3 echoes selection: one position, zero velocity.
// - Bit 2 is signal degradation flag, bit 1 tracking loss flag.
// - Bit 0 makes the whole word hold an odd count of ones.
// - Serial: read strobe fall loads shift register; data driven while low.
// - MSB valid by first serial clock fall; shift on each rise, 15 more.
// - Extra serial clocks after bit zero shift out zeros.
// - Serial enable high: all twelve pins form the parallel bus.
// - Latch strobe rising edge clears monitor minimum and maximum registers.
//
// All host pins are sampled by SYS_CLK through two flops, so pin responses lag by
// about three cycles; the serial clock must be well below SYS_CLK / 4 in practice.
`include "avrp_defines.svh"
module avrp_port
	import avrp_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire avrp_data_t POSITION_INTEGRATOR,
	input  wire avrp_data_t VELOCITY_INTEGRATOR,
	input  wire logic       SIGNAL_DEGRADE_FLAG,
	input  wire logic       TRACKING_LOST_FLAG,
	input  wire logic       LATCH_STROBE_N,
	input  wire logic       CHIP_SELECT_N,
	input  wire logic       READ_STROBE_N,
	input  wire logic       REGISTER_SELECT,
	input  wire logic       SERIAL_PORT_ENABLE_N,
	input  wire avrp_data_t DATA_PIN_IN,
	output avrp_data_t      DATA_PIN_OUT,
	output avrp_data_t      DATA_PIN_OE,
	output logic            MONITOR_CLEAR,
	output avrp_data_t      POSITION_HELD,
	output avrp_data_t      VELOCITY_HELD
);
	typedef struct packed
	{
		avrp_data_t  pos_hold_ff;
		avrp_data_t  vel_hold_ff;
		avrp_data_t  par_out_ff;
		avrp_word_t  shift_ff;
		logic        drive_ff;
		logic        clear_ff;
		avrp_frame_e frame_ff;
	} avrp_port_s;

	avrp_port_s st_ff;
	avrp_port_s nxt_st;

	logic latch_lvl;
	logic latch_rise;
	logic latch_fall;
	logic cs_lvl;
	logic rd_lvl;
	logic rd_rise;
	logic rd_fall;
	logic sel_lvl;
	logic soe_lvl;
	logic sclk_lvl;
	logic sclk_rise;
	logic sclk_fall;
	avrp_data_t chosen;
	avrp_word_t word;

	// Every pin comes from the host's domain, so each passes its own synchroniser.
	avrp_sync u_latch
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (LATCH_STROBE_N),
		.level   (latch_lvl),
		.rise    (latch_rise),
		.fall    (latch_fall)
	);

	avrp_sync u_cs
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (CHIP_SELECT_N),
		.level   (cs_lvl),
		.rise    (),
		.fall    ()
	);

	avrp_sync u_rd
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (READ_STROBE_N),
		.level   (rd_lvl),
		.rise    (rd_rise),
		.fall    (rd_fall)
	);

	avrp_sync u_sel
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (REGISTER_SELECT),
		.level   (sel_lvl),
		.rise    (),
		.fall    ()
	);

	avrp_sync u_soe
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (SERIAL_PORT_ENABLE_N),
		.level   (soe_lvl),
		.rise    (),
		.fall    ()
	);

	// The serial clock shares the data pin ten; it idles high between frames.
	avrp_sync u_sclk
	(
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.din     (DATA_PIN_IN[`AVRP_SCLK_PIN]),
		.level   (sclk_lvl),
		.rise    (sclk_rise),
		.fall    (sclk_fall)
	);

	assign chosen = sel_lvl ? st_ff.pos_hold_ff : st_ff.vel_hold_ff;

	avrp_word u_word
	(
		.data    (chosen),
		.select  (sel_lvl),
		.degrade (SIGNAL_DEGRADE_FLAG),
		.lost    (TRACKING_LOST_FLAG),
		.word    (word)
	);

	always_comb
	begin
		nxt_st          = st_ff;
		nxt_st.clear_ff = latch_rise;
		// Integrators are inputs that keep moving; only the holding copies freeze.
		if (latch_fall)
		begin
			nxt_st.pos_hold_ff = POSITION_INTEGRATOR;
			nxt_st.vel_hold_ff = VELOCITY_INTEGRATOR;
		end
		unique case (st_ff.frame_ff)
			AVRP_IDLE:
			begin
				if (rd_fall && !cs_lvl)
				begin
					nxt_st.par_out_ff = chosen;
					nxt_st.shift_ff   = word;
					nxt_st.drive_ff   = 1'b1;
					nxt_st.frame_ff   = AVRP_FRAME;
				end
			end
			AVRP_FRAME:
			begin
				if (rd_lvl || cs_lvl)
				begin
					nxt_st.drive_ff = 1'b0;
					nxt_st.frame_ff = AVRP_IDLE;
				end
				else if (sclk_rise && !soe_lvl)
					nxt_st.shift_ff = {st_ff.shift_ff[`AVRP_WORD_W-2:0], 1'b0};
			end
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			st_ff.pos_hold_ff <= `AVRP_RST_DATA;
			st_ff.vel_hold_ff <= `AVRP_RST_DATA;
			st_ff.par_out_ff  <= `AVRP_RST_DATA;
			st_ff.shift_ff    <= `AVRP_RST_WORD;
			st_ff.drive_ff    <= 1'b0;
			st_ff.clear_ff    <= 1'b0;
			st_ff.frame_ff    <= AVRP_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	always_comb
	begin
		DATA_PIN_OUT = st_ff.par_out_ff;
		DATA_PIN_OE  = '0;
		if (soe_lvl)
		begin
			if (st_ff.drive_ff)
				DATA_PIN_OE = '1;
		end
		else
		begin
			DATA_PIN_OUT[`AVRP_SO_PIN] = st_ff.shift_ff[`AVRP_WORD_W-1];
			DATA_PIN_OE[`AVRP_SO_PIN]  = st_ff.drive_ff;
		end
	end

	assign MONITOR_CLEAR = st_ff.clear_ff;
	assign POSITION_HELD = st_ff.pos_hold_ff;
	assign VELOCITY_HELD = st_ff.vel_hold_ff;
endmodule : avrp_port

// ==== tb/avrp_port_monitor.sv ====
// Pin timing checker for the read-out port.
module avrp_port_monitor
	import avrp_pkg::*;
(
	input wire logic	SYS_CLK,
	input wire logic	RST,
	input wire avrp_data_t	POSITION_INTEGRATOR,
	input wire avrp_data_t	VELOCITY_INTEGRATOR,
	input wire logic	SIGNAL_DEGRADE_FLAG,
	input wire logic	TRACKING_LOST_FLAG,
	input wire logic	LATCH_STROBE_N,
	input wire logic	CHIP_SELECT_N,
	input wire logic	READ_STROBE_N,
	input wire logic	REGISTER_SELECT,
	input wire logic	SERIAL_PORT_ENABLE_N,
	input wire avrp_data_t	DATA_PIN_IN,
	input wire avrp_data_t	DATA_PIN_OUT,
	input wire avrp_data_t	DATA_PIN_OE,
	input wire logic	MONITOR_CLEAR,
	input wire avrp_data_t	POSITION_HELD,
	input wire avrp_data_t	VELOCITY_HELD
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// A pin edge first sampled at edge n shows on registered outputs sampled at edge n+3.
	sequence s_sclk_rose;
		$past(DATA_PIN_IN[10], 3) && !$past(DATA_PIN_IN[10], 5);
	endsequence
	sequence s_latch_fell;
		!$past(LATCH_STROBE_N, 3) && $past(LATCH_STROBE_N, 4);
	endsequence
	a_drive_needs_read: assert property (DATA_PIN_OE[0] |->
		!$past(READ_STROBE_N, 3) && !$past(CHIP_SELECT_N, 3)) else $error("Bus driven unread");
	a_release_after_read: assert property ($rose(READ_STROBE_N) |->
		##[1:5] !DATA_PIN_OE[0]) else $error("Bus not released");
	a_select_on_bus: assert property ($rose(DATA_PIN_OE[0]) |-> DATA_PIN_OUT ==
		(REGISTER_SELECT ? POSITION_HELD : VELOCITY_HELD)) else $error("Wrong word on bus");
	a_latch_copies: assert property ($fell(LATCH_STROBE_N) |-> ##4
		POSITION_HELD == POSITION_INTEGRATOR && VELOCITY_HELD == VELOCITY_INTEGRATOR)
		else $error("Latch missed");
	a_hold_frozen: assert property ($changed(POSITION_HELD) |-> s_latch_fell)
		else $error("Hold moved");
	a_monitor_pulse: assert property (MONITOR_CLEAR |->
		($past(LATCH_STROBE_N, 3) && !$past(LATCH_STROBE_N, 4)) ##1 !MONITOR_CLEAR)
		else $error("Bad clear pulse");
	a_serial_pins_float: assert property (!$past(SERIAL_PORT_ENABLE_N, 3) &&
		!SERIAL_PORT_ENABLE_N |-> DATA_PIN_OE[10:0] == 11'h000) else $error("Serial pins driven");
	a_shift_on_rise: assert property (DATA_PIN_OE[11] && $past(DATA_PIN_OE[11]) &&
		$changed(DATA_PIN_OUT[11]) |-> s_sclk_rose) else $error("Shift off clock rise");
endmodule : avrp_port_monitor
bind avrp_port avrp_port_monitor u_mon (.*);

// ==== tb/avrp_host.sv ====
// Serial host model: runs the serial clock and gathers the bits.
module avrp_host
(
	input wire logic	go,
	input wire logic	so,
	input wire logic	so_oe,
	output logic	sclk,
	output logic	done,
	output logic [17:0]	word
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		sclk = 1'b1;
		done = 1'b0;
		word = 18'h00000;
	end
	// Two clocks past bit zero check the zero fill; a floating line reads inverted.
	always @(posedge go)
	begin
		done = 1'b0;
		#1037;
		for (int i = 17; i >= 0; i--)
		begin
			sclk = 1'b0;
			#200 word[i] = so_oe ? so : ~so;
			#200 sclk = 1'b1;
			#400;
		end
		done = 1'b1;
	end
endmodule : avrp_host

// ==== tb/tb_avrp_port.sv ====
// Self-checking bench for the read-out port.
module tb_avrp_port
	import avrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic	SYS_CLK = 1'b0, RST = 1'b1, LATCH_STROBE_N = 1'b1, CHIP_SELECT_N = 1'b1;
	logic	READ_STROBE_N = 1'b1, REGISTER_SELECT = 1'b0, SERIAL_PORT_ENABLE_N = 1'b1;
	logic	SIGNAL_DEGRADE_FLAG = 1'b0, TRACKING_LOST_FLAG = 1'b0, MONITOR_CLEAR, go = 1'b0;
	logic	done, sclk;
	avrp_data_t	POSITION_INTEGRATOR = '0, VELOCITY_INTEGRATOR = '0, DATA_PIN_OUT, DATA_PIN_OE;
	avrp_data_t	POSITION_HELD, VELOCITY_HELD, pos_exp, vel_exp, rnd_pins = '0;
	logic [17:0]	got;
	logic [31:0]	seed = 32'h00016b15;
	int	mismatches = 0, checks_done = 0;
	wire avrp_data_t	DATA_PIN_IN = {rnd_pins[11], sclk, rnd_pins[9:0]};
	avrp_port u_dut (.*);
	avrp_host u_host (.go(go), .so(DATA_PIN_OUT[11]), .so_oe(DATA_PIN_OE[11]), .sclk(sclk),
		.done(done), .word(got));
	always #50 SYS_CLK = ~SYS_CLK;
	function automatic avrp_data_t rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[11:0];
	endfunction : rnd
	function automatic avrp_word_t exp_word(input avrp_data_t d, input logic s, dg, lt);
		return {d, s, dg, lt, ~^{d, s, dg, lt}};
	endfunction : exp_word
	task automatic cmp_pins(input avrp_data_t g, e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error at %0t: pins %h not %h", $time, g, e);
		end
	endtask : cmp_pins
	task automatic cmp_word(input avrp_word_t g, e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error at %0t: word %h not %h", $time, g, e);
		end
	endtask : cmp_word
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask : cyc
	task automatic latch(input avrp_data_t p, v);
		pos_exp = p;
		vel_exp = v;
		POSITION_INTEGRATOR <= p;
		VELOCITY_INTEGRATOR <= v;
		LATCH_STROBE_N <= 1'b0;
		cyc(4);
		LATCH_STROBE_N <= 1'b1;
		cyc(4);
		cmp_pins(avrp_data_t'(MONITOR_CLEAR), 12'h001);
		cyc(1);
		cmp_pins(avrp_data_t'(MONITOR_CLEAR), 12'h000);
		cyc(3);
		cmp_pins(POSITION_HELD, p);
		cmp_pins(VELOCITY_HELD, v);
		$display("Latch test done");
	endtask : latch
	task automatic start(input logic sel, cs_n);
		REGISTER_SELECT <= sel;
		CHIP_SELECT_N <= cs_n;
		READ_STROBE_N <= 1'b0;
		POSITION_INTEGRATOR <= rnd();
		VELOCITY_INTEGRATOR <= rnd();
		rnd_pins <= rnd();
	endtask : start
	task automatic finish_read();
		READ_STROBE_N <= 1'b1;
		CHIP_SELECT_N <= 1'b1;
		cyc(6);
		cmp_pins(DATA_PIN_OE, 12'h000);
		$display("Read test done at %0t", $time);
	endtask : finish_read
	task automatic pread(input logic sel, cs_n);
		start(sel, cs_n);
		cyc(6);
		cmp_pins(DATA_PIN_OE, cs_n ? 12'h000 : 12'hfff);
		if (!cs_n) cmp_pins(DATA_PIN_OUT, sel ? pos_exp : vel_exp);
		finish_read();
	endtask : pread
	task automatic sread(input logic sel, dg, lt);
		start(sel, 1'b0);
		SIGNAL_DEGRADE_FLAG <= dg;
		TRACKING_LOST_FLAG <= lt;
		go <= 1'b1;
		cyc(2);
		go <= 1'b0;
		repeat (300) if (done !== 1'b1) cyc(1);
		cmp_word(got[17:2], exp_word(sel ? pos_exp : vel_exp, sel, dg, lt));
		cmp_word(avrp_word_t'(got[1:0]), 16'h0000);
		cmp_pins(DATA_PIN_OE, 12'h800);
		finish_read();
	endtask : sread
	task automatic results();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	initial
	begin
		cyc(16);
		RST <= 1'b0;
		cyc(2);
		latch(12'hfff, 12'h800);
		for (int i = 0; i < 6; i++) pread(i[0], i == 5);
		latch(12'h000, 12'h7ff);
		SERIAL_PORT_ENABLE_N <= 1'b0;
		cyc(4);
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4) latch(rnd(), rnd());
			sread(i[0], i[1], i[2]);
		end
		results();
	end
	initial
	begin
		#400000;
		mismatches++;
		results();
	end
endmodule : tb_avrp_port
